// ===== bench/switch_model.sv
// Behavioural model of the left and right reference switches
`timescale 1ns/1ps
module switch_model (
   input wire logic hclk,
   input wire logic want_l,
   input wire logic want_r,
   output logic ref_switch_l,
   output logic ref_switch_r
);
   // Contacts change just after an edge; one process drives both contacts
   always @(posedge hclk) begin
      ref_switch_l <= want_l;
      ref_switch_r <= want_r;
   end
endmodule : switch_model

// ===== bench/tb_top.sv
// Self-checking bench for the switch latch block over AHB-Lite
`timescale 1ns/1ps
module tb_top;
   import latch_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hresp, irq, position_reached, want_l, want_r, sw_l, sw_r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, act, tgt, regulated_error, rd;
   logic [9:0] regulator_gain;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   switch_model partner (.hclk(hclk), .want_l(want_l), .want_r(want_r), .ref_switch_l(sw_l),
      .ref_switch_r(sw_r));
   switch_latch dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .ref_switch_l(sw_l), .ref_switch_r(sw_r),
      .actual_position(act), .target_position(tgt), .regulated_error(regulated_error),
      .regulator_gain(regulator_gain), .position_reached(position_reached), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////
   // Clock and watchdog; the watchdog ceiling is far above the roughly 160 cycles needed
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails = fails + 1;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task end_of_test();
      if (fails == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One single word transfer; the address phase is held until hready is seen high
   task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask : bus
   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdchk
   task tick(input int n);
      repeat (n) @(posedge hclk);
   endtask : tick
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      want_l = 1'b0;
      want_r = 1'b0;
      act = 32'hA5A5_1234;
      tgt = 32'h0000_0000;
      tick(10);
      hresetn <= 1'b1;
      rdchk(LATCH_POS_ADDR, 32'h0000_0000);
      rdchk(PREG_CTRL_ADDR, 32'h1000_0000);
      rdchk(RAMP_STATUS_ADDR, 32'h0000_0000);
      bus(1'b1, LATCH_POS_ADDR, 32'hFFFF_FFFF);
      rdchk(LATCH_POS_ADDR, 32'h0000_0000);
      // Left switch, capture on activation only
      bus(1'b1, SWITCH_MODE_ADDR, 32'h0000_0001);
      want_l <= 1'b1;
      tick(6);
      rdchk(RAMP_STATUS_ADDR, 32'h0000_0005);
      rdchk(LATCH_POS_ADDR, 32'hA5A5_1234);
      act <= 32'h0000_0077;
      want_l <= 1'b0;
      tick(6);
      rdchk(RAMP_STATUS_ADDR, 32'h0000_0004);
      rdchk(LATCH_POS_ADDR, 32'hA5A5_1234);
      bus(1'b1, RAMP_STATUS_ADDR, 32'h0000_0004);
      rdchk(RAMP_STATUS_ADDR, 32'h0000_0000);
      // Right switch, capture on release only
      bus(1'b1, SWITCH_MODE_ADDR, 32'h0000_0008);
      want_r <= 1'b1;
      tick(6);
      rdchk(RAMP_STATUS_ADDR, 32'h0000_0002);
      want_r <= 1'b0;
      tick(6);
      rdchk(RAMP_STATUS_ADDR, 32'h0000_0008);
      rdchk(LATCH_POS_ADDR, 32'h0000_0077);
      // Interrupt: masked in, masked out, then cleared
      bus(1'b1, IRQ_MASK_ADDR, 32'h0000_0008);
      tick(3);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, IRQ_MASK_ADDR, 32'h0000_0000);
      tick(3);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, IRQ_MASK_ADDR, 32'h0000_0008);
      bus(1'b1, RAMP_STATUS_ADDR, 32'h0000_0008);
      tick(3);
      check({31'h0, irq}, 32'h0);
      // Regulator dead band at its edges, tolerance always applied
      bus(1'b1, PREG_CTRL_ADDR, 32'h0010_03FF);
      tgt <= 32'h0000_007C;
      tick(3);
      check({22'h0, regulator_gain}, 32'h0000_03FF);
      check(regulated_error, 32'h0000_0000);
      tgt <= 32'h0000_0087;
      tick(3);
      check(regulated_error, 32'h0000_0010);
      tgt <= 32'h0000_0068;
      tick(3);
      check(regulated_error, 32'h0000_0000);
      tgt <= 32'h0000_0067;
      tick(3);
      check(regulated_error, 32'hFFFF_FFF0);
      tgt <= 32'h0000_0077;
      tick(3);
      rdchk(RAMP_STATUS_ADDR, 32'h0000_0200);
      // Tolerance gated by position reached, which is now clear
      bus(1'b1, PREG_CTRL_ADDR, 32'h1010_0000);
      tgt <= 32'h0000_007C;
      tick(3);
      check({31'h0, position_reached}, 32'h0);
      check(regulated_error, 32'h0000_0005);
      // Remaining transitions: right latches on activation, left on release
      bus(1'b1, SWITCH_MODE_ADDR, 32'h0000_0006);
      rdchk(SWITCH_MODE_ADDR, 32'h0000_0006);
      act <= 32'h0000_1111;
      want_r <= 1'b1;
      tick(6);
      rdchk(RAMP_STATUS_ADDR, 32'h0000_000A);
      rdchk(LATCH_POS_ADDR, 32'h0000_1111);
      check({31'h0, irq}, 32'h1);
      want_l <= 1'b1;
      tick(6);
      rdchk(RAMP_STATUS_ADDR, 32'h0000_000B);
      rdchk(LATCH_POS_ADDR, 32'h0000_1111);
      act <= 32'h0000_2222;
      want_l <= 1'b0;
      tick(6);
      rdchk(RAMP_STATUS_ADDR, 32'h0000_000E);
      rdchk(LATCH_POS_ADDR, 32'h0000_2222);
      // Left flag alone drives the interrupt once the right one is cleared
      bus(1'b1, RAMP_STATUS_ADDR, 32'h0000_0008);
      tick(3);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, IRQ_MASK_ADDR, 32'h0000_0004);
      rdchk(IRQ_MASK_ADDR, 32'h0000_0004);
      tick(2);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, RAMP_STATUS_ADDR, 32'h0000_0004);
      tick(3);
      check({31'h0, irq}, 32'h0);
      rdchk(RAMP_STATUS_ADDR, 32'h0000_0002);
      rdchk(12'hFF0, 32'h0000_0000);
      end_of_test();
   end
endmodule : tb_top

// ===== pkg/latch_pkg.sv
// Package: register map, field layout, reset values and carriers for the switch latch block
package latch_pkg;
   // Register indices as printed; the byte address is four times the index
   localparam logic [9:0] LATCH_POS_INDEX = 10'h061;
   localparam logic [9:0] PREG_CTRL_INDEX = 10'h062;
   localparam logic [11:0] LATCH_POS_ADDR = {LATCH_POS_INDEX, 2'b00};
   localparam logic [11:0] PREG_CTRL_ADDR = {PREG_CTRL_INDEX, 2'b00};
   localparam logic [11:0] RAMP_STATUS_ADDR = 12'h000;
   localparam logic [11:0] SWITCH_MODE_ADDR = 12'h004;
   localparam logic [11:0] IRQ_MASK_ADDR = 12'h008;

   // Ramp status fields
   localparam int STAT_STOP_L_BIT = 0;
   localparam int STAT_STOP_R_BIT = 1;
   localparam int STAT_LATCH_L_BIT = 2;
   localparam int STAT_LATCH_R_BIT = 3;
   localparam int STAT_POS_REACHED_BIT = 9;

   // Position regulator control fields
   localparam int PREG_GAIN_LSB = 0;
   localparam int PREG_GAIN_MSB = 9;
   localparam int PREG_TOL_LSB = 16;
   localparam int PREG_TOL_MSB = 23;
   localparam int PREG_EN_TOL_BIT = 28;

   // Reset values
   localparam logic [31:0] LATCH_POS_RESET = 32'h0000_0000;
   localparam logic [9:0] PREG_GAIN_RESET = 10'h000;
   localparam logic [7:0] PREG_TOL_RESET = 8'h00;
   localparam logic PREG_EN_TOL_RESET = 1'b1;
   localparam logic [3:0] SWITCH_MODE_RESET = 4'h0;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

   // Switch mode: which transitions latch the position
   typedef struct packed {
      logic latch_r_inactive;
      logic latch_r_active;
      logic latch_l_inactive;
      logic latch_l_active;
   } switch_mode_s;

   // Captured AHB address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [11:0] addr;
   } addr_phase_s;

   // Position regulator control
   typedef struct packed {
      logic en_tol_on_pos_reached;
      logic [7:0] tolerance;
      logic [9:0] gain;
   } preg_ctrl_s;
endpackage : latch_pkg

// ===== verilog/switch_latch.sv
// Reference switch position latch with position regulator tolerance and AHB-Lite registers
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
// Summary of operation
// - Right latch sets status bit 3, left sets bit 2; writing one clears.
// - Status bit 1 reads the live right switch, one while active.
// - Status bit 0 reads the live left switch, one while active.
// - Selected switch transition copies the full actual position into the latch register.
// - Tolerance applies always when bit 28 clear, only at position reached when set.
// - Position errors smaller than the tolerance field are treated as zero.
// - Position reached flag stays set while actual equals target position.
module switch_latch
   import latch_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ref_switch_l,
   input wire logic ref_switch_r,
   input wire logic [31:0] actual_position,
   input wire logic [31:0] target_position,
   output logic [31:0] regulated_error,
   output logic [9:0] regulator_gain,
   output logic position_reached,
   output logic irq
);
   addr_phase_s dphase;
   switch_mode_s switch_mode_config;
   preg_ctrl_s preg_ctrl;
   logic [31:0] latched_position;
   logic [1:0] latch_flag;
   logic [1:0] irq_mask;
   logic sw_l;
   logic sw_r;
   logic rise_l;
   logic fall_l;
   logic rise_r;
   logic fall_r;
   logic event_l;
   logic event_r;
   logic wr_status;
   logic [31:0] pos_error;
   logic [31:0] error_mag;
   logic tol_allowed;
   logic [31:0] next_error;
   logic [31:0] next_rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Switch inputs
   switch_sync left_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(ref_switch_l),
      .level(sw_l),
      .went_active(rise_l),
      .went_inactive(fall_l)
   );

   switch_sync right_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(ref_switch_r),
      .level(sw_r),
      .went_active(rise_r),
      .went_inactive(fall_r)
   );

   // Latch events selected by the switch mode
   always_comb begin
      event_l = (switch_mode_config.latch_l_active & rise_l) | (switch_mode_config.latch_l_inactive & fall_l);
      event_r = (switch_mode_config.latch_r_active & rise_r) | (switch_mode_config.latch_r_inactive & fall_r);
      wr_status = dphase.valid & dphase.write & (dphase.addr == RAMP_STATUS_ADDR);
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite address phase capture; zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dphase <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         dphase.valid <= hsel & htrans[1] & hready;
         dphase.write <= hwrite;
         dphase.addr <= haddr[11:0];
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Read data is prepared in the address phase so it stands from a flop in the data phase
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (haddr[11:0] == RAMP_STATUS_ADDR) begin
         next_rdata[STAT_STOP_L_BIT] = sw_l;
         next_rdata[STAT_STOP_R_BIT] = sw_r;
         next_rdata[STAT_LATCH_L_BIT] = latch_flag[0];
         next_rdata[STAT_LATCH_R_BIT] = latch_flag[1];
         next_rdata[STAT_POS_REACHED_BIT] = position_reached;
      end else if (haddr[11:0] == SWITCH_MODE_ADDR) begin
         next_rdata[3:0] = switch_mode_config;
      end else if (haddr[11:0] == IRQ_MASK_ADDR) begin
         next_rdata[STAT_LATCH_R_BIT:STAT_LATCH_L_BIT] = irq_mask;
      end else if (haddr[11:0] == LATCH_POS_ADDR) begin
         next_rdata = latched_position;
      end else if (haddr[11:0] == PREG_CTRL_ADDR) begin
         next_rdata[PREG_EN_TOL_BIT] = preg_ctrl.en_tol_on_pos_reached;
         next_rdata[PREG_TOL_MSB:PREG_TOL_LSB] = preg_ctrl.tolerance;
         next_rdata[PREG_GAIN_MSB:PREG_GAIN_LSB] = preg_ctrl.gain;
      end
   end

   // Read data register; unmapped addresses read zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hsel && htrans[1] && hready && !hwrite) begin
         hrdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Writable control registers; the latch register has no write path at all
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         switch_mode_config <= SWITCH_MODE_RESET;
         irq_mask <= IRQ_MASK_RESET;
         preg_ctrl.en_tol_on_pos_reached <= PREG_EN_TOL_RESET;
         preg_ctrl.tolerance <= PREG_TOL_RESET;
         preg_ctrl.gain <= PREG_GAIN_RESET;
      end else if (dphase.valid && dphase.write) begin
         if (dphase.addr == SWITCH_MODE_ADDR) begin
            switch_mode_config <= hwdata[3:0];
         end else if (dphase.addr == IRQ_MASK_ADDR) begin
            irq_mask <= hwdata[STAT_LATCH_R_BIT:STAT_LATCH_L_BIT];
         end else if (dphase.addr == PREG_CTRL_ADDR) begin
            preg_ctrl.en_tol_on_pos_reached <= hwdata[PREG_EN_TOL_BIT];
            preg_ctrl.tolerance <= hwdata[PREG_TOL_MSB:PREG_TOL_LSB];
            preg_ctrl.gain <= hwdata[PREG_GAIN_MSB:PREG_GAIN_LSB];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Position capture; both events in one cycle capture the same value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         latched_position <= LATCH_POS_RESET;
      end else if (event_l || event_r) begin
         latched_position <= actual_position;
      end
   end

   // Latch ready flags: an event in the clearing cycle wins over the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         latch_flag <= 2'b00;
      end else begin
         latch_flag[0] <= event_l | (latch_flag[0] & ~(wr_status & hwdata[STAT_LATCH_L_BIT]));
         latch_flag[1] <= event_r | (latch_flag[1] & ~(wr_status & hwdata[STAT_LATCH_R_BIT]));
      end
   end

   // Level interrupt from unmasked latch flags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(latch_flag & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Regulator error with tolerance dead band
   always_comb begin
      pos_error = target_position - actual_position;
      error_mag = pos_error[31] ? (32'h0000_0000 - pos_error) : pos_error;
      tol_allowed = ~preg_ctrl.en_tol_on_pos_reached | position_reached;
      next_error = pos_error;
      if (tol_allowed && (error_mag < {24'h00_0000, preg_ctrl.tolerance})) begin
         next_error = 32'h0000_0000;
      end
   end

   // Regulator outputs and position reached flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         regulated_error <= 32'h0000_0000;
         regulator_gain <= PREG_GAIN_RESET;
         position_reached <= 1'b0;
      end else begin
         regulated_error <= next_error;
         regulator_gain <= preg_ctrl.gain;
         position_reached <= (actual_position == target_position);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_latch_r_set: assert property (@(posedge hclk) disable iff (!hresetn) event_r |=> latch_flag[1])
      else $error("right latch flag not set after event");
   a_latch_l_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_status && hwdata[STAT_LATCH_L_BIT] && !event_l) |=> !latch_flag[0])
      else $error("left latch flag not cleared by write one");
   a_switch_r_live: assert property (@(posedge hclk) disable iff (!hresetn)
      ref_switch_r [*3] |-> sw_r)
      else $error("right switch status not active");
   a_switch_l_live: assert property (@(posedge hclk) disable iff (!hresetn)
      (!ref_switch_l) [*3] |-> !sw_l)
      else $error("left switch status not inactive");
   a_capture_position: assert property (@(posedge hclk) disable iff (!hresetn)
      (event_l || event_r) |=> latched_position == $past(actual_position))
      else $error("latched position differs from captured position");
   a_tol_always: assert property (@(posedge hclk) disable iff (!hresetn)
      (!preg_ctrl.en_tol_on_pos_reached && error_mag < {24'h00_0000, preg_ctrl.tolerance})
      |=> regulated_error == 32'h0000_0000)
      else $error("error inside tolerance not ignored");
   a_tol_gated: assert property (@(posedge hclk) disable iff (!hresetn)
      (preg_ctrl.en_tol_on_pos_reached && !position_reached) |=> regulated_error == $past(pos_error))
      else $error("tolerance applied before position reached");
   a_tol_outside: assert property (@(posedge hclk) disable iff (!hresetn)
      (error_mag >= {24'h00_0000, preg_ctrl.tolerance}) |=> regulated_error == $past(pos_error))
      else $error("error outside tolerance suppressed");
   a_pos_reached: assert property (@(posedge hclk) disable iff (!hresetn)
      (actual_position == target_position) |=> position_reached)
      else $error("position reached flag not set");
   a_latch_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      (!event_l && !event_r) |=> $stable(latched_position))
      else $error("latched position changed without event");

   c_left_capture: cover property (@(posedge hclk) disable iff (!hresetn) event_l ##1 latch_flag[0]);
   c_right_capture: cover property (@(posedge hclk) disable iff (!hresetn) event_r ##1 latch_flag[1]);
   c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
   c_set_and_clear: cover property (@(posedge hclk) disable iff (!hresetn) wr_status && event_r);
endmodule : switch_latch

// ===== verilog/switch_sync.sv
// Reference switch synchroniser with transition detection
`timescale 1ns/1ps
module switch_sync (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin,
   output logic level,
   output logic went_active,
   output logic went_inactive
);
   logic meta;
   logic prev;

   ////////////////////////////////////////////////////////////////////////////
   // Two stages before anything looks at the pin; only the second is used
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta <= 1'b0;
         level <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= pin;
         level <= meta;
         prev <= level;
      end
   end

   // Edges are taken from settled stages so a glitchy first stage cannot fire twice
   always_comb begin
      went_active = level & ~prev;
      went_inactive = ~level & prev;
   end
endmodule : switch_sync
